/* File: shared/gcdc_pkg.sv */
// Package: register map, field layout, timing and shared types of the gain/chop/detect block
package gcdc_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_GAIN = 6'h04; // Channel gain select
    localparam logic [5:0] IDX_RSVD = 6'h05; // Reserved word
    localparam logic [5:0] IDX_CFG = 6'h06; // Chop and detect configuration
    localparam logic [5:0] IDX_TH_HI = 6'h07; // Threshold upper part
    localparam logic [5:0] IDX_TH_LO = 6'h08; // Threshold lower part
    localparam logic [5:0] IDX_IRQ_STAT = 6'h10; // Sticky event status, read only
    localparam logic [5:0] IDX_IRQ_CLR = 6'h11; // Event clear, write only
    localparam logic [5:0] IDX_IRQ_EN = 6'h12; // Event enable
    localparam logic [5:0] IDX_ENG_STAT = 6'h13; // Engine phase and counter state

    // ----------------------------------------------------------------
    // Field positions and widths
    // ----------------------------------------------------------------
    localparam int GAIN_W = 3; // Gain code width, bits 2:0
    localparam int CFG_W = 13; // Stored configuration bits 12:0
    localparam int CFG_DET_EN = 0; // Detect mode enable
    localparam int CFG_LEN_LSB = 1; // Window length code 3:1
    localparam int CFG_NUM_LSB = 4; // Exceedance count code 6:4
    localparam int CFG_ALL = 7; // All-channels select
    localparam int CFG_CHOP = 8; // Chop enable
    localparam int CFG_DLY_LSB = 9; // Chop settle delay code 12:9
    localparam int TH_LO_LSB = 8; // Threshold low byte sits at 15:8
    localparam int IRQ_W = 3; // Number of event bits
    localparam int IRQ_DET = 0; // Detection declared
    localparam int IRQ_WIN = 1; // Measurement window ended
    localparam int IRQ_SETTLE = 2; // Chop settling finished
    localparam int NCH = 3; // Monitored channels
    localparam int SAMPLE_W = 24; // Conversion result width
    localparam int DLY_W = 17; // Settle counter width, up to 65536
    localparam int WIN_W = 12; // Window counter width, up to 3584

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] GAIN_RST = 3'h0;
    localparam logic [15:0] RSVD_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0600;
    localparam logic [15:0] TH_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {GCDC_IDLE, GCDC_SETTLE, GCDC_MEASURE} gcdc_phase_t;
    typedef logic [NCH-1:0][SAMPLE_W-1:0] gcdc_samples_t;
    typedef struct packed {
        logic valid; // One-cycle conversion strobe
        gcdc_samples_t data; // Signed results, one per channel
    } gcdc_conv_t;
    typedef struct packed {
        logic [7:0] address; // Byte address
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } gcdc_avs_req_t;
    typedef struct packed {
        logic busy;
        logic [DLY_W-1:0] cnt;
        logic done;
    } gcdc_timer_st_t;
    typedef struct packed {
        logic [7:0] cnt;
    } gcdc_cnt_st_t;
    typedef struct packed {
        logic [GAIN_W-1:0] gain_sel;
        logic [15:0] rsvd;
        logic [CFG_W-1:0] cfg;
        logic [15:0] th_hi;
        logic [7:0] th_lo;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        gcdc_phase_t phase;
        logic [WIN_W-1:0] win_cnt;
        logic det_seen;
        logic waitreq;
        logic [31:0] rdata;
        logic [7:0] gain_factor;
        logic measure;
        logic det_pulse;
        logic irq;
    } gcdc_top_st_t;

    // ----------------------------------------------------------------
    // Shared decoders
    // ----------------------------------------------------------------
    // Power of two from a 3-bit code: 1 .. 128
    function automatic logic [7:0] gcdc_pow2_8(input logic [2:0] code);
        return 8'h01 << code;
    endfunction

    // Settle delay in modulator periods: 2 .. 65536
    function automatic logic [DLY_W-1:0] gcdc_chop_len(input logic [3:0] code);
        return 17'h00002 << code;
    endfunction

    // Window length in conversion periods
    function automatic logic [WIN_W-1:0] gcdc_win_len(input logic [2:0] code);
        logic [WIN_W-1:0] len;
        len = 12'h080;
        unique case (code)
            3'h0: len = 12'h080;
            3'h1: len = 12'h100;
            3'h2: len = 12'h200;
            3'h3: len = 12'h300;
            3'h4: len = 12'h500;
            3'h5: len = 12'h700;
            3'h6: len = 12'hA00;
            3'h7: len = 12'hE00;
        endcase
        return len;
    endfunction

    // Magnitude of a signed sample
    function automatic logic [SAMPLE_W-1:0] gcdc_mag(input logic [SAMPLE_W-1:0] s);
        return s[SAMPLE_W-1] ? (~s + 24'h000001) : s;
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] gcdc_merge16(input logic [15:0] old,
                                                 input logic [15:0] wd,
                                                 input logic [1:0] be);
        return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

endpackage

/* File: design/gcdc_settle_timer.sv */
// Chop settling timer counting modulator clock periods
module gcdc_settle_timer (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic mod_tick,
    input wire logic [3:0] dly_code,
    output logic done
);
    import gcdc_pkg::*;

    gcdc_timer_st_t st_q; // Registered state
    gcdc_timer_st_t st_d; // Next state

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (start)
        begin
            // Restart from zero
            st_d.busy = 1'b1;
            st_d.cnt = '0;
        end
        else if (st_q.busy && mod_tick)
        begin
            // Last period of the selected delay
            if (st_q.cnt == gcdc_chop_len(dly_code) - 17'h00001)
            begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end
            else
            begin
                st_d.cnt = st_q.cnt + 17'h00001;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign done = st_q.done;

endmodule // gcdc_settle_timer

/* File: design/gcdc_exceed_counter.sv */
// Saturating per-channel count of threshold exceedances
module gcdc_exceed_counter (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic hit,
    input wire logic [7:0] target,
    output logic reached
);
    import gcdc_pkg::*;

    gcdc_cnt_st_t st_q; // Registered state
    gcdc_cnt_st_t st_d; // Next state

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        if (clear)
            st_d.cnt = '0; // New window
        else if (hit && st_q.cnt != 8'hFF)
            st_d.cnt = st_q.cnt + 8'h01; // Saturate, never wrap
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign reached = (st_q.cnt >= target);

endmodule // gcdc_exceed_counter

/* File: design/gcdc_top.sv */
// Gain, chop and current-detect configuration with detection engine
//
// Notes on behaviour
// - Gain code 2:0 selects 1 to 128
// - Config word resets to 0600h
// - Chop waits 2 to 65536 modulator periods
// - Bit 7 selects any or all channels
// - Exceedances needed: 1 to 128
// - Window length 128 to 3584 conversions
// - Bit 0 enables detect mode
// - Threshold split into upper and lower part
//
// Local design decision: the Avalon-MM interface to the registers.
module gcdc_top (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire gcdc_pkg::gcdc_avs_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic mod_tick,
    input wire gcdc_pkg::gcdc_conv_t conv,
    output logic [7:0] ch0_gain_factor,
    output logic measure_active,
    output logic detect_pulse,
    output logic irq
);
    import gcdc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    gcdc_top_st_t st_q; // All registered state
    gcdc_top_st_t st_d; // Next state
    logic [31:0] rd_word; // Read mux result
    logic [5:0] idx; // Word index of the access
    logic wr_commit; // Write takes effect this edge
    logic [IRQ_W-1:0] ev; // Events raised this cycle
    logic [IRQ_W-1:0] clr; // Clears written this cycle
    logic timer_start; // Launch chop settling
    logic timer_done; // Settling finished
    logic cnt_clear; // Reset exceedance counters
    logic [NCH-1:0] ch_hit; // Sample above threshold
    logic [NCH-1:0] ch_reached; // Count target met
    logic det_hit; // Detection condition
    logic [SAMPLE_W-1:0] thr; // Full comparison threshold
    logic [WIN_W-1:0] win_len; // Selected window length
    logic [7:0] num_target; // Selected exceedance count

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    assign thr = {st_q.th_hi, st_q.th_lo};
    assign win_len = gcdc_win_len(st_q.cfg[CFG_LEN_LSB +: 3]);
    assign num_target = gcdc_pow2_8(st_q.cfg[CFG_NUM_LSB +: 3]);
    assign idx = avs_req.address[7:2];
    assign wr_commit = avs_req.write && !st_q.waitreq;

    // Per-channel magnitude compare and counters
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_ch
            // Exceedance on a conversion inside the window
            assign ch_hit[ch] = (st_q.phase == GCDC_MEASURE) && conv.valid
                                && (gcdc_mag(conv.data[ch]) > thr);
            gcdc_exceed_counter u_cnt (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .clear(cnt_clear),
                .hit(ch_hit[ch]),
                .target(num_target),
                .reached(ch_reached[ch])
            );
        end
    endgenerate

    // Any or all channels must reach the count
    assign det_hit = st_q.cfg[CFG_ALL] ? (&ch_reached) : (|ch_reached);

    // Chop settling timer
    gcdc_settle_timer u_settle (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(timer_start),
        .mod_tick(mod_tick),
        .dly_code(st_q.cfg[CFG_DLY_LSB +: 4]),
        .done(timer_done)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        ev = '0;
        clr = '0;
        timer_start = 1'b0;
        cnt_clear = 1'b0;
        st_d.det_pulse = 1'b0;

        // Read mux; unmapped words read zero
        rd_word = 32'h00000000;
        unique case (idx)
            IDX_GAIN: rd_word = {29'h00000000, st_q.gain_sel};
            IDX_RSVD: rd_word = {16'h0000, st_q.rsvd};
            IDX_CFG: rd_word = {19'h00000, st_q.cfg}; // Bits 15:13 read zero
            IDX_TH_HI: rd_word = {16'h0000, st_q.th_hi};
            IDX_TH_LO: rd_word = {16'h0000, st_q.th_lo, 8'h00};
            IDX_IRQ_STAT: rd_word = {29'h00000000, st_q.irq_stat};
            IDX_IRQ_EN: rd_word = {29'h00000000, st_q.irq_en};
            IDX_ENG_STAT: rd_word = {13'h0000, ch_reached, st_q.win_cnt,
                                     2'h0, st_q.phase};
            default: rd_word = 32'h00000000;
        endcase

        // Bus handshake: one wait cycle, then answer
        if ((avs_req.read || avs_req.write) && st_q.waitreq)
        begin
            st_d.waitreq = 1'b0;
            st_d.rdata = rd_word;
        end
        else
        begin
            st_d.waitreq = 1'b1;
        end

        // Register writes at the accepting edge
        if (wr_commit)
        begin
            unique case (idx)
                IDX_GAIN:
                    if (avs_req.byteenable[0])
                        st_d.gain_sel = avs_req.writedata[GAIN_W-1:0];
                IDX_RSVD:
                    st_d.rsvd = gcdc_merge16(st_q.rsvd, avs_req.writedata[15:0],
                                             avs_req.byteenable[1:0]);
                IDX_CFG: // Upper three bits dropped
                    st_d.cfg = CFG_W'(gcdc_merge16({3'h0, st_q.cfg},
                                                   avs_req.writedata[15:0],
                                                   avs_req.byteenable[1:0]));
                IDX_TH_HI:
                    st_d.th_hi = gcdc_merge16(st_q.th_hi, avs_req.writedata[15:0],
                                              avs_req.byteenable[1:0]);
                IDX_TH_LO:
                    if (avs_req.byteenable[1])
                        st_d.th_lo = avs_req.writedata[TH_LO_LSB +: 8];
                IDX_IRQ_CLR:
                    if (avs_req.byteenable[0])
                        clr = avs_req.writedata[IRQ_W-1:0];
                IDX_IRQ_EN:
                    if (avs_req.byteenable[0])
                        st_d.irq_en = avs_req.writedata[IRQ_W-1:0];
                default:
                    ; // Unmapped or read-only: ignored
            endcase
        end

        // Detection engine
        unique case (st_q.phase)
            GCDC_IDLE:
                if (st_q.cfg[CFG_DET_EN])
                begin
                    cnt_clear = 1'b1;
                    st_d.win_cnt = '0;
                    st_d.det_seen = 1'b0;
                    if (st_q.cfg[CFG_CHOP])
                    begin
                        // Settle before the first window
                        timer_start = 1'b1;
                        st_d.phase = GCDC_SETTLE;
                    end
                    else
                    begin
                        st_d.phase = GCDC_MEASURE;
                    end
                end
            GCDC_SETTLE:
                if (timer_done)
                begin
                    // Settling over, measurement begins
                    ev[IRQ_SETTLE] = 1'b1;
                    st_d.phase = GCDC_MEASURE;
                end
            GCDC_MEASURE:
            begin
                // Detection flagged once per window
                if (det_hit && !st_q.det_seen)
                begin
                    st_d.det_seen = 1'b1;
                    st_d.det_pulse = 1'b1;
                    ev[IRQ_DET] = 1'b1;
                end
                if (conv.valid)
                begin
                    if (st_q.win_cnt == win_len - 12'h001)
                    begin
                        // Window complete, start the next one
                        ev[IRQ_WIN] = 1'b1;
                        cnt_clear = 1'b1;
                        st_d.win_cnt = '0;
                        st_d.det_seen = 1'b0;
                        if (st_q.cfg[CFG_CHOP])
                        begin
                            timer_start = 1'b1;
                            st_d.phase = GCDC_SETTLE;
                        end
                    end
                    else
                    begin
                        st_d.win_cnt = st_q.win_cnt + 12'h001;
                    end
                end
            end
            default:
                st_d.phase = GCDC_IDLE;
        endcase

        // Disabling the mode stops the engine at once
        if (!st_q.cfg[CFG_DET_EN])
            st_d.phase = GCDC_IDLE;

        // Sticky events: a set in the clearing cycle wins
        st_d.irq_stat = (st_q.irq_stat & ~clr) | ev;
        st_d.irq = |(st_d.irq_stat & st_d.irq_en);

        // Registered outputs
        st_d.gain_factor = gcdc_pow2_8(st_d.gain_sel);
        st_d.measure = (st_d.phase == GCDC_MEASURE);
    end

    // ----------------------------------------------------------------
    // State register with synchronous reset
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
            st_q.gain_sel <= GAIN_RST;
            st_q.rsvd <= RSVD_RST;
            st_q.cfg <= CFG_RST[CFG_W-1:0];
            st_q.th_hi <= TH_RST;
            st_q.th_lo <= TH_RST[7:0];
            st_q.phase <= GCDC_IDLE;
            st_q.waitreq <= 1'b1;
            st_q.gain_factor <= 8'h01;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign avs_readdata = st_q.rdata;
    assign avs_waitrequest = st_q.waitreq;
    assign ch0_gain_factor = st_q.gain_factor;
    assign measure_active = st_q.measure;
    assign detect_pulse = st_q.det_pulse;
    assign irq = st_q.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // Gain output follows the stored code
    gain_decode_a: assert property (ch0_gain_factor == (8'h01 << st_q.gain_sel))
        else $error("gain factor does not match code");

    // Config word reads 0600h right after reset
    cfg_reset_a: assert property ($past(!reset_n) |-> st_q.cfg == 13'h0600)
        else $error("config word reset value wrong");

    // Measurement after chop only follows settle done
    chop_settle_a: assert property (
        $rose(measure_active) && st_q.cfg[CFG_CHOP] |-> $past(timer_done))
        else $error("measurement began before settling ended");

    // All-channels mode needs every counter reached
    all_channels_a: assert property (
        st_d.det_pulse && st_q.cfg[CFG_ALL] |-> &ch_reached)
        else $error("detection without all channels");

    // Detection needs at least one counter at target
    exceed_count_a: assert property (detect_pulse |-> $past(|ch_reached))
        else $error("detection before exceed count reached");

    // Window counter stays inside the selected length
    window_len_a: assert property (
        st_q.phase == GCDC_MEASURE |-> st_q.win_cnt < win_len)
        else $error("window counter beyond length");

    // Disabled mode leaves the engine idle
    mode_off_a: assert property (!st_q.cfg[CFG_DET_EN] |=> st_q.phase == GCDC_IDLE)
        else $error("engine active while disabled");

    // Threshold low write keeps only bits 15:8
    thresh_join_a: assert property (
        wr_commit && idx == IDX_TH_LO && avs_req.byteenable[1]
        |=> st_q.th_lo == $past(avs_req.writedata[TH_LO_LSB +: 8]))
        else $error("threshold low part not stored");

    // A detection raises the sticky status bit next cycle
    detect_flag_a: assert property (
        st_d.det_pulse |=> st_q.irq_stat[IRQ_DET] && detect_pulse)
        else $error("detection not flagged");

    // Accepted access returns waitrequest high next cycle
    bus_answer_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest stuck low");

    // Gain write stores the low three bits
    gain_write_a: assert property (
        wr_commit && idx == IDX_GAIN && avs_req.byteenable[0]
        |=> st_q.gain_sel == $past(avs_req.writedata[GAIN_W-1:0]))
        else $error("gain code not stored");

    // Full config write keeps bits 12:0 only
    cfg_write_a: assert property (
        wr_commit && idx == IDX_CFG && (&avs_req.byteenable[1:0])
        |=> st_q.cfg == $past(avs_req.writedata[CFG_W-1:0]))
        else $error("config word not stored");

    // Last conversion of a window raises the window status bit
    window_end_a: assert property (
        st_q.phase == GCDC_MEASURE && conv.valid && st_q.win_cnt == win_len - 12'h001
        |=> st_q.irq_stat[IRQ_WIN])
        else $error("window end not flagged");

    // Interrupt is high while an enabled status bit is set
    irq_level_a: assert property (irq == |(st_q.irq_stat & st_q.irq_en))
        else $error("interrupt level wrong");

    // Main scenarios
    cov_detect_c: cover property (detect_pulse);
    cov_window_c: cover property (ev[IRQ_WIN]);
    cov_chop_c: cover property (st_q.phase == GCDC_SETTLE ##[1:300] measure_active);
    cov_irq_c: cover property ($rose(irq));

endmodule // gcdc_top

/* File: tb/test_gain_chop_detect_config.sv */
// Testbench: register map, gain decode, chop settling and detection engine
module test_gain_chop_detect_config;
    timeunit 1ns;
    timeprecision 1ns;
    import gcdc_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic mod_tick = 1'b0;
    gcdc_avs_req_t avs_req = '0;
    gcdc_conv_t conv = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, measure_active, detect_pulse, irq;
    logic [7:0] ch0_gain_factor;
    logic [31:0] q; // Last read data
    logic [15:0] v; // Random config value
    int num_errors = 0, total_checks = 0, dets = 0, seed = 52614;

    gcdc_top u_gcdc_top (.core_clk(core_clk), .reset_n(reset_n), .avs_req(avs_req),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mod_tick(mod_tick),
        .conv(conv), .ch0_gain_factor(ch0_gain_factor), .measure_active(measure_active),
        .detect_pulse(detect_pulse), .irq(irq));

    // ----------------------------------------------------------------
    // Clock, detection counter, watchdog
    // ----------------------------------------------------------------
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (detect_pulse === 1'b1) dets <= dets + 1;
    initial
    begin
        #1000000;
        num_errors++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_req <= '{address: a, read: !wr, write: wr, writedata: {16'h0000, d},
                     byteenable: 4'hF};
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) num_errors++;
        q = avs_readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 16'h0000);
        chk(q, exp);
    endtask

    // Config rewrite through idle so every window starts fresh
    task automatic wcfg(input logic [15:0] d);
        bus(1'b1, 8'h18, 16'h0000);
        bus(1'b1, 8'h18, d);
    endtask

    task automatic cv(input logic [23:0] a0, input logic [23:0] a1, input logic [23:0] a2);
        @(posedge core_clk);
        conv <= '{valid: 1'b1, data: {a2, a1, a0}};
        @(posedge core_clk);
        conv.valid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic tick();
        @(posedge core_clk);
        mod_tick <= 1'b1;
        @(posedge core_clk);
        mod_tick <= 1'b0;
    endtask

    // Small random sample, below every threshold used here
    function automatic logic [23:0] sm();
        return 24'($random(seed)) & 24'h0007FF;
    endfunction

    function automatic logic [31:0] gexp(input logic [2:0] c);
        return 32'h00000001 << c;
    endfunction

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(8'h18, 32'h00000600);
        rd(8'h14, 32'h00000000);
        rd(8'h10, 32'h00000000);
        rd(8'h7C, 32'h00000000);
        chk({31'h0, measure_active}, 32'h0);
        chk({24'h0, ch0_gain_factor}, 32'h1);
        for (int c = 0; c < 8; c++)
        begin
            bus(1'b1, 8'h10, 16'(c));
            rd(8'h10, 32'(c));
            chk({24'h0, ch0_gain_factor}, gexp(3'(c)));
        end
        repeat (4)
        begin
            v = 16'($random(seed)) & 16'h1FFE;
            bus(1'b1, 8'h18, v);
            rd(8'h18, {16'h0, v});
        end
        // Threshold 0x001000, detection event enabled
        bus(1'b1, 8'h1C, 16'h0010);
        bus(1'b1, 8'h20, 16'h0000);
        rd(8'h1C, 32'h00000010);
        bus(1'b1, 8'h48, 16'h0001);
        wcfg(16'h0081);
        repeat (2) cv(24'h100000, sm(), sm());
        chk(32'(dets), 32'h0);
        cv(24'h100000, 24'hF00000, 24'h100001);
        chk(32'(dets), 32'h1);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h48, 16'h0000);
        rd(8'h40, 32'h00000001);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 8'h48, 16'h0001);
        rd(8'h44, 32'h00000000);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 8'h44, 16'h0001);
        rd(8'h40, 32'h00000000);
        chk({31'h0, irq}, 32'h0);
        wcfg(16'h0001);
        cv(sm(), sm(), 24'hF00000);
        chk(32'(dets), 32'h2);
        wcfg(16'h0011);
        cv(24'h100000, sm(), sm());
        chk(32'(dets), 32'h2);
        cv(24'h200000, sm(), sm());
        chk(32'(dets), 32'h3);
        // Window of 128 conversions, threshold out of reach
        bus(1'b1, 8'h1C, 16'hFFFF);
        bus(1'b1, 8'h20, 16'hFF00);
        wcfg(16'h0001);
        bus(1'b1, 8'h44, 16'h0007);
        repeat (127) cv(sm(), sm(), sm());
        rd(8'h40, 32'h00000000);
        cv(sm(), sm(), sm());
        rd(8'h40, 32'h00000002);
        // Chop with delay code 0: two modulator periods
        wcfg(16'h0101);
        bus(1'b1, 8'h44, 16'h0007);
        tick();
        repeat (3) @(posedge core_clk);
        chk({31'h0, measure_active}, 32'h0);
        tick();
        repeat (3) @(posedge core_clk);
        chk({31'h0, measure_active}, 32'h1);
        rd(8'h40, 32'h00000004);
        bus(1'b1, 8'h18, 16'h0000);
        rd(8'h18, 32'h00000000);
        chk({31'h0, measure_active}, 32'h0);
        final_report();
    end
endmodule // test_gain_chop_detect_config
